// File: rtl/lsdd_pulse.v
// line voltage measurement pulse timer, width proportional to millivolts
`timescale 1ns/1ps
`include "lsdd_regs.vh"
`default_nettype none
module lsdd_pulse #(
    parameter MV_W = `LSDD_MV_W,
    parameter CNT_W = 32
) (
    // clock and reset
    input wire clk,
    input wire rst_n,
    input wire ce,
    // control
    input wire start,
    input wire abort,
    input wire [MV_W-1:0] mv,
    // status
    output reg busy_ff,
    output reg done_ff
);
    reg [CNT_W-1:0] acc_ff;
    reg [CNT_W-1:0] nxt_acc;
    reg nxt_busy;
    // accumulate ps per mv scaled; counts down in clock periods
    // remainder below one clock period is not carried over, so each pulse at 5.5 us/V rounds up to whole clock periods
    always @* begin
        nxt_acc = acc_ff;
        nxt_busy = busy_ff;
        if (abort) begin
            nxt_busy = 1'b0;
        end else if (start) begin
            nxt_acc = mv * `LSDD_PS_PER_MV;
            nxt_busy = (mv != {MV_W{1'b0}});
        end else if (busy_ff) begin
            if (acc_ff <= `LSDD_CLK_PS) begin
                nxt_acc = {CNT_W{1'b0}};
                nxt_busy = 1'b0;
            end else begin
                nxt_acc = acc_ff - `LSDD_CLK_PS;
            end
        end
    end
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            acc_ff <= {CNT_W{1'b0}};
            busy_ff <= 1'b0;
            done_ff <= 1'b0;
        end else if (ce) begin
            acc_ff <= nxt_acc;
            busy_ff <= nxt_busy;
            done_ff <= busy_ff & ~nxt_busy & ~abort;
        end
    end
endmodule
`default_nettype wire

// File: rtl/lsdd_regs.vh
// register offsets, fields, reset values and timing counts of the line state decoder
`ifndef LSDD_REGS_VH
`define LSDD_REGS_VH
// register byte addresses
`define LSDD_ADDR_CTRL 8'h00
`define LSDD_ADDR_STATUS 8'h04
`define LSDD_ADDR_IRQ_STAT 8'h08
`define LSDD_ADDR_IRQ_MASK 8'h0C
`define LSDD_ADDR_CODES 8'h10
`define LSDD_ADDR_MEAS 8'h14
// control fields
`define LSDD_CTRL_GKSEL 0
`define LSDD_CTRL_SWSEL 1
`define LSDD_CTRL_SWCODE_LO 2
`define LSDD_CTRL_SWCODE_HI 4
`define LSDD_CTRL_RST 32'h0000_0000
// status fields
`define LSDD_ST_STATE_LO 0
`define LSDD_ST_STATE_HI 2
`define LSDD_ST_DET 3
`define LSDD_ST_RELAY 4
`define LSDD_ST_MEAS 5
`define LSDD_ST_THERM 6
// interrupt bits
`define LSDD_IRQ_STATE 0
`define LSDD_IRQ_DETFALL 1
`define LSDD_IRQ_MEASDONE 2
`define LSDD_IRQ_THERM 3
`define LSDD_IRQ_W 4
// control codes: fixed ones and default table (active,tipopen,rev,meas)
`define LSDD_CODE_OPEN 3'h0
`define LSDD_CODE_RING 3'h1
`define LSDD_CODES_RST 12'hF35
// decoded line states
`define LSDD_ST_W 3
`define LSDD_S_OPEN 3'h0
`define LSDD_S_RING 3'h1
`define LSDD_S_ACT 3'h2
`define LSDD_S_TIPO 3'h3
`define LSDD_S_REV 3'h4
`define LSDD_S_MEAS 3'h5
`define LSDD_S_BAD 3'h6
// measurement pulse scale: picoseconds per millivolt and clock period
`define LSDD_PS_PER_MV 5500
`define LSDD_CLK_PS 40000
`define LSDD_MV_W 16
`endif

// File: rtl/lsdd_sync.v
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module lsdd_sync #(
    parameter W = 1,
    parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
    // clock and reset
    input wire clk,
    input wire rst_n,
    input wire ce,
    // data
    input wire [W-1:0] d,
    output wire [W-1:0] q
);
    reg [W-1:0] meta_ff;
    reg [W-1:0] sync_ff;
    // first stage feeds only the second
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_ff <= RST_VAL;
            sync_ff <= RST_VAL;
        end else if (ce) begin
            meta_ff <= d;
            sync_ff <= meta_ff;
        end
    end
    assign q = sync_ff;
endmodule
`default_nettype wire

// File: rtl/lsdd_top.v
// line state decoder with detector multiplexer and wishbone registers
//
// The register addresses and the Wishbone interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`include "lsdd_regs.vh"
`default_nettype none
module lsdd_top #(
    parameter MV_W = `LSDD_MV_W
) (
    // clock, reset, enable
    input wire CLK,
    input wire RST_N,
    input wire CE,
    // control word pins, pulled up outside when undriven
    input wire STATE_SELECT_BIT0,
    input wire STATE_SELECT_BIT1,
    input wire STATE_SELECT_BIT2,
    // detector comparator pins
    input wire LOOP_OFFHOOK,
    input wire GROUND_KEY,
    input wire RING_TRIP,
    input wire THERMAL_GUARD,
    input wire [MV_W-1:0] LINE_MV,
    // wishbone slave
    input wire WB_CYC_I,
    input wire WB_STB_I,
    input wire WB_WE_I,
    input wire [7:0] WB_ADR_I,
    input wire [3:0] WB_SEL_I,
    input wire [31:0] WB_DAT_I,
    output reg [31:0] WB_DAT_O,
    output reg WB_ACK_O,
    // line side outputs
    output reg SHARED_DETECTOR_OUT,
    output reg RING_RELAY_DRV,
    output reg TIP_LINE_TERMINAL_EN,
    output reg RING_LINE_TERMINAL_EN,
    output reg POLARITY_REVERSED,
    output reg BLOCKS_POWERED,
    output reg IRQ
);
    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers; control pins reset to one like their pull-ups
    wire [2:0] sel_s;
    wire [3:0] det_s;
    wire [MV_W-1:0] mv_s;
    lsdd_sync #(.W(3), .RST_VAL(3'h7)) u_sync_sel (
        .clk(CLK),
        .rst_n(RST_N),
        .ce(CE),
        .d({STATE_SELECT_BIT2, STATE_SELECT_BIT1, STATE_SELECT_BIT0}),
        .q(sel_s)
    );
    lsdd_sync #(.W(4), .RST_VAL(4'h0)) u_sync_det (
        .clk(CLK),
        .rst_n(RST_N),
        .ce(CE),
        .d({THERMAL_GUARD, RING_TRIP, GROUND_KEY, LOOP_OFFHOOK}),
        .q(det_s)
    );
    // the voltage word is assumed quasi-static while it is sampled
    lsdd_sync #(.W(MV_W), .RST_VAL({MV_W{1'b0}})) u_sync_mv (
        .clk(CLK),
        .rst_n(RST_N),
        .ce(CE),
        .d(LINE_MV),
        .q(mv_s)
    );
    wire loop_s = det_s[0];
    wire gkey_s = det_s[1];
    wire trip_s = det_s[2];
    wire therm_s = det_s[3];

    // a changing voltage word can be caught mid-update by the sync flops;
    // only take it once two synced samples agree
    reg [MV_W-1:0] mv_prev_ff;
    reg [MV_W-1:0] mv_hold_ff;
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            mv_prev_ff <= {MV_W{1'b0}};
            mv_hold_ff <= {MV_W{1'b0}};
        end else if (CE) begin
            mv_prev_ff <= mv_s;
            if (mv_s == mv_prev_ff)
                mv_hold_ff <= mv_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registers
    reg [31:0] ctrl_ff;
    reg [11:0] codes_ff;
    reg [`LSDD_IRQ_W-1:0] irq_stat_ff;
    reg [`LSDD_IRQ_W-1:0] irq_mask_ff;
    reg [2:0] state_ff;
    reg [2:0] nxt_state;
    reg meas_ok_ff;
    reg [MV_W-1:0] meas_mv_ff;
    wire pulse_busy;
    wire pulse_done;

    // code table: active, tip open, reversal, measure in 3-bit slots
    function [2:0] decode;
        input [2:0] code;
        input [11:0] tbl;
        begin
            if (code == `LSDD_CODE_OPEN)
                decode = `LSDD_S_OPEN;
            else if (code == `LSDD_CODE_RING)
                decode = `LSDD_S_RING;
            else if (code == tbl[2:0])
                decode = `LSDD_S_ACT;
            else if (code == tbl[5:3])
                decode = `LSDD_S_TIPO;
            else if (code == tbl[8:6])
                decode = `LSDD_S_REV;
            else if (code == tbl[11:9])
                decode = `LSDD_S_MEAS;
            else
                decode = `LSDD_S_BAD;
        end
    endfunction

    // software may override the pins for bring-up
    wire [2:0] code_eff = ctrl_ff[`LSDD_CTRL_SWSEL] ?
        ctrl_ff[`LSDD_CTRL_SWCODE_HI:`LSDD_CTRL_SWCODE_LO] : sel_s;
    wire gk_sel = ctrl_ff[`LSDD_CTRL_GKSEL];

    ////////////////////////////////////////////////////////////////////////
    // state decode; unknown codes fall back to open circuit for safety
    always @* begin
        nxt_state = decode(code_eff, codes_ff);
        if (nxt_state == `LSDD_S_BAD)
            nxt_state = `LSDD_S_OPEN;
    end

    // measurement only allowed when entered from an active state
    wire enter_meas = (nxt_state == `LSDD_S_MEAS) &&
                      (state_ff != `LSDD_S_MEAS);
    wire from_active = (state_ff == `LSDD_S_ACT) ||
                       (state_ff == `LSDD_S_REV);
    wire meas_start = enter_meas && from_active;
    wire meas_abort = (state_ff == `LSDD_S_MEAS) &&
                      (nxt_state != `LSDD_S_MEAS);

    lsdd_pulse #(.MV_W(MV_W)) u_pulse (
        .clk(CLK),
        .rst_n(RST_N),
        .ce(CE),
        .start(meas_start),
        .abort(meas_abort),
        .mv(mv_hold_ff),
        .busy_ff(pulse_busy),
        .done_ff(pulse_done)
    );

    ////////////////////////////////////////////////////////////////////////
    // detector multiplexer, thermal guard has top priority
    reg nxt_det;
    always @* begin
        case (state_ff)
            `LSDD_S_OPEN: nxt_det = 1'b1;
            `LSDD_S_RING: nxt_det = ~trip_s;
            `LSDD_S_ACT, `LSDD_S_REV: begin
                // reversal keeps the active selection
                nxt_det = gk_sel ? gkey_s : ~loop_s;
            end
            `LSDD_S_TIPO: nxt_det = ~loop_s;
            `LSDD_S_MEAS: nxt_det = meas_ok_ff & pulse_busy;
            default: nxt_det = 1'b1;
        endcase
        if (therm_s)
            nxt_det = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // line state and outputs
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            state_ff <= `LSDD_S_OPEN;
            meas_ok_ff <= 1'b0;
            meas_mv_ff <= {MV_W{1'b0}};
            SHARED_DETECTOR_OUT <= 1'b1;
            RING_RELAY_DRV <= 1'b0;
            TIP_LINE_TERMINAL_EN <= 1'b0;
            RING_LINE_TERMINAL_EN <= 1'b0;
            POLARITY_REVERSED <= 1'b0;
            BLOCKS_POWERED <= 1'b0;
        end else if (CE) begin
            state_ff <= nxt_state;
            if (enter_meas) begin
                meas_ok_ff <= from_active;
                meas_mv_ff <= mv_hold_ff;
            end
            SHARED_DETECTOR_OUT <= nxt_det;
            RING_RELAY_DRV <= (nxt_state == `LSDD_S_RING);
            // open circuit powers everything down
            BLOCKS_POWERED <= (nxt_state != `LSDD_S_OPEN);
            TIP_LINE_TERMINAL_EN <= (nxt_state != `LSDD_S_OPEN) &&
                                    (nxt_state != `LSDD_S_TIPO);
            RING_LINE_TERMINAL_EN <= (nxt_state != `LSDD_S_OPEN);
            POLARITY_REVERSED <= (nxt_state == `LSDD_S_REV);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt events
    reg det_prev_ff;
    reg therm_prev_ff;
    wire [`LSDD_IRQ_W-1:0] ev;
    assign ev[`LSDD_IRQ_STATE] = (nxt_state != state_ff);
    assign ev[`LSDD_IRQ_DETFALL] = det_prev_ff & ~SHARED_DETECTOR_OUT;
    assign ev[`LSDD_IRQ_MEASDONE] = pulse_done;
    assign ev[`LSDD_IRQ_THERM] = therm_s & ~therm_prev_ff;

    ////////////////////////////////////////////////////////////////////////
    // wishbone slave, ack one cycle after the request, then drop
    wire wb_req = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
    // writes land at the ack edge, the same edge the master commits on
    wire wb_wr = WB_CYC_I & WB_STB_I & WB_ACK_O & WB_WE_I;

    function [31:0] lane_merge;
        input [31:0] old;
        input [31:0] dat;
        input [3:0] sel;
        integer i;
        begin
            lane_merge = old;
            for (i = 0; i < 4; i = i + 1)
                if (sel[i])
                    lane_merge[i*8 +: 8] = dat[i*8 +: 8];
        end
    endfunction

    wire [31:0] ctrl_w = lane_merge(ctrl_ff, WB_DAT_I, WB_SEL_I);
    wire [31:0] codes_w = lane_merge({20'h0_0000, codes_ff}, WB_DAT_I,
                                     WB_SEL_I);
    wire [31:0] mask_w = lane_merge({28'h000_0000, irq_mask_ff}, WB_DAT_I,
                                    WB_SEL_I);
    wire [`LSDD_IRQ_W-1:0] w1c = (wb_wr && WB_ADR_I == `LSDD_ADDR_IRQ_STAT
                                  && WB_SEL_I[0]) ?
                                 WB_DAT_I[`LSDD_IRQ_W-1:0] :
                                 {`LSDD_IRQ_W{1'b0}};

    // read mux
    reg [31:0] rd;
    always @* begin
        rd = 32'h0000_0000;
        case (WB_ADR_I)
            `LSDD_ADDR_CTRL: rd = ctrl_ff;
            `LSDD_ADDR_STATUS: begin
                rd[`LSDD_ST_STATE_HI:`LSDD_ST_STATE_LO] = state_ff;
                rd[`LSDD_ST_DET] = SHARED_DETECTOR_OUT;
                rd[`LSDD_ST_RELAY] = RING_RELAY_DRV;
                rd[`LSDD_ST_MEAS] = pulse_busy;
                rd[`LSDD_ST_THERM] = therm_s;
            end
            `LSDD_ADDR_IRQ_STAT: rd[`LSDD_IRQ_W-1:0] = irq_stat_ff;
            `LSDD_ADDR_IRQ_MASK: rd[`LSDD_IRQ_W-1:0] = irq_mask_ff;
            `LSDD_ADDR_CODES: rd[11:0] = codes_ff;
            `LSDD_ADDR_MEAS: rd[MV_W-1:0] = meas_mv_ff;
            default: rd = 32'h0000_0000; // unmapped reads zero, still acked
        endcase
    end

    // register write, ack and interrupt; set wins over write-one clear
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            ctrl_ff <= `LSDD_CTRL_RST;
            codes_ff <= `LSDD_CODES_RST;
            irq_stat_ff <= {`LSDD_IRQ_W{1'b0}};
            irq_mask_ff <= {`LSDD_IRQ_W{1'b0}};
            det_prev_ff <= 1'b1;
            therm_prev_ff <= 1'b0;
            WB_ACK_O <= 1'b0;
            WB_DAT_O <= 32'h0000_0000;
            IRQ <= 1'b0;
        end else if (CE) begin
            WB_ACK_O <= wb_req;
            if (wb_req)
                WB_DAT_O <= rd;
            if (wb_wr && WB_ADR_I == `LSDD_ADDR_CTRL)
                ctrl_ff <= {26'h000_0000, ctrl_w[5:0]};
            if (wb_wr && WB_ADR_I == `LSDD_ADDR_CODES)
                codes_ff <= codes_w[11:0];
            if (wb_wr && WB_ADR_I == `LSDD_ADDR_IRQ_MASK)
                irq_mask_ff <= mask_w[`LSDD_IRQ_W-1:0];
            irq_stat_ff <= (irq_stat_ff & ~w1c) | ev;
            det_prev_ff <= SHARED_DETECTOR_OUT;
            therm_prev_ff <= therm_s;
            IRQ <= |(((irq_stat_ff & ~w1c) | ev) & irq_mask_ff);
        end
    end
endmodule
`default_nettype wire

// File: tb/lsdd_ctl_model.sv
// line card controller model: drives state pins, votes on ringing
`timescale 1ns/1ps
`default_nettype none
module lsdd_ctl_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // requested code and pin release
    input wire logic [2:0] code,
    input wire logic rel,
    // detector sample and verdict
    input wire logic shared_detector_out,
    output logic [2:0] pins,
    output logic offhook
);
    logic [4:0] win_ff;
    logic [5:0] low_ff;
    logic hook_ff;
    ////////////////////////////////////////////////////////////////////////
    // released pins float to one through the pull-ups
    assign pins = rel ? 3'h7 : code;
    assign offhook = hook_ff;
    // ringing toggles the output, so judge by low duty over 32 samples
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            win_ff <= 5'h0;
            low_ff <= 6'h0;
            hook_ff <= 1'b0;
        end else begin
            win_ff <= win_ff + 5'h1;
            if (win_ff == 5'h1F) begin
                hook_ff <= (low_ff + {5'h0, !shared_detector_out}) > 6'h10;
                low_ff <= 6'h0;
            end else begin
                low_ff <= low_ff + {5'h0, !shared_detector_out};
            end
        end
    end
endmodule
`default_nettype wire

// File: tb/lsdd_properties.sv
// port checker for the line state decoder, bound to the top module
`timescale 1ns/1ps
`default_nettype none
module lsdd_checker (
    // clock, reset, enable
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic CE,
    // bus handshake
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_ACK_O,
    // detectors and line side
    input wire logic RING_TRIP,
    input wire logic THERMAL_GUARD,
    input wire logic SHARED_DETECTOR_OUT,
    input wire logic RING_RELAY_DRV,
    input wire logic TIP_LINE_TERMINAL_EN,
    input wire logic POLARITY_REVERSED,
    input wire logic BLOCKS_POWERED
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);
    ////////////////////////////////////////////////////////////////////////
    // bus reply is one cycle after a fresh request and lasts one cycle
    chk_ack_reply: assert property (CE && WB_CYC_I && WB_STB_I && !WB_ACK_O
        |=> WB_ACK_O) else $error("no ack after request");
    chk_ack_pulse: assert property (CE && WB_ACK_O |=> !WB_ACK_O)
        else $error("ack longer than one cycle");
    // pin inputs pass two sync flops, so allow five samples of settling
    chk_therm_low: assert property (THERMAL_GUARD[*5]
        |-> !SHARED_DETECTOR_OUT) else $error("thermal not forcing low");
    chk_open_det_high: assert property (
        (!THERMAL_GUARD)[*5] ##0 (!BLOCKS_POWERED)[*2]
        |-> SHARED_DETECTOR_OUT)
        else $error("open circuit output not high");
    chk_relay_power: assert property (
        RING_RELAY_DRV |-> BLOCKS_POWERED)
        else $error("ringing with blocks down");
    chk_ring_trip: assert property (
        (RING_RELAY_DRV && RING_TRIP && !THERMAL_GUARD)[*5]
        |-> !SHARED_DETECTOR_OUT) else $error("ring trip not low");
    chk_ring_idle: assert property (
        (RING_RELAY_DRV && !RING_TRIP && !THERMAL_GUARD)[*5]
        |-> SHARED_DETECTOR_OUT) else $error("ringing on-hook not high");
    chk_rev_drive: assert property (POLARITY_REVERSED
        |-> TIP_LINE_TERMINAL_EN && !RING_RELAY_DRV)
        else $error("reversal drive wrong");
    // main scenarios reached
    cov_ring_trip: cover property (RING_RELAY_DRV && !SHARED_DETECTOR_OUT);
    cov_reversal: cover property (POLARITY_REVERSED);
    cov_tip_open: cover property (BLOCKS_POWERED && !TIP_LINE_TERMINAL_EN);
endmodule
bind lsdd_top lsdd_checker u_chk (.CLK(CLK), .RST_N(RST_N), .CE(CE),
    .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_ACK_O(WB_ACK_O),
    .RING_TRIP(RING_TRIP), .THERMAL_GUARD(THERMAL_GUARD),
    .SHARED_DETECTOR_OUT(SHARED_DETECTOR_OUT),
    .RING_RELAY_DRV(RING_RELAY_DRV),
    .TIP_LINE_TERMINAL_EN(TIP_LINE_TERMINAL_EN),
    .POLARITY_REVERSED(POLARITY_REVERSED),
    .BLOCKS_POWERED(BLOCKS_POWERED));
`default_nettype wire

// File: tb/tb.sv
// self-checking bench for the line state decoder
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk, rst_n, ce, loop_oh, gkey, rtrip, therm, cyc, stb, we, rel;
    logic [15:0] mv;
    logic [7:0] adr;
    logic [31:0] wdat, q;
    logic [2:0] code;
    wire logic [2:0] pins;
    wire logic [31:0] rdat;
    wire logic ack, sdo, relay, tip_en, ring_en, rev, pwr, irq, offhook;
    int mismatches = 0;
    int n_tests = 0;
    int n;
    ////////////////////////////////////////////////////////////////////////
    lsdd_top dut (.CLK(clk), .RST_N(rst_n), .CE(ce),
        .STATE_SELECT_BIT0(pins[0]), .STATE_SELECT_BIT1(pins[1]),
        .STATE_SELECT_BIT2(pins[2]), .LOOP_OFFHOOK(loop_oh),
        .GROUND_KEY(gkey), .RING_TRIP(rtrip), .THERMAL_GUARD(therm),
        .LINE_MV(mv), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
        .WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(wdat),
        .WB_DAT_O(rdat), .WB_ACK_O(ack), .SHARED_DETECTOR_OUT(sdo),
        .RING_RELAY_DRV(relay), .TIP_LINE_TERMINAL_EN(tip_en),
        .RING_LINE_TERMINAL_EN(ring_en), .POLARITY_REVERSED(rev),
        .BLOCKS_POWERED(pwr), .IRQ(irq));
    lsdd_ctl_model ctl (.clk(clk), .rst_n(rst_n), .code(code), .rel(rel),
        .shared_detector_out(sdo), .pins(pins), .offhook(offhook));
    ////////////////////////////////////////////////////////////////////////
    // compares for single bits and bus words
    task automatic chk1(input logic got, input logic exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one classic cycle, entered right after an edge; waits for ack
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
        int k;
        k = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk);
            k++;
        end while (ack !== 1'b1 && k < 20);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        chk1(ack, 1'b1);
        @(posedge clk);
    endtask
    task automatic tick(input int c);
        repeat (c) @(posedge clk);
    endtask
    // pins settle through two sync flops plus the state register
    task automatic setc(input logic [2:0] c);
        code <= c;
        tick(8);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        wb(1'b0, 8'h0C, 32'h0);
        chk32(q, 32'h0000_0000);
        wb(1'b1, 8'h20, 32'hFFFF_FFFF);
        wb(1'b0, 8'h20, 32'h0);
        chk32(q, 32'h0000_0000);
        wb(1'b1, 8'h10, 32'h0000_0F2B); // active 3, tip open 5
        wb(1'b0, 8'h10, 32'h0);
        chk32(q & 32'h0000_0FFF, 32'h0000_0F2B);
        loop_oh <= 1'b1;
        setc(3'h3);
        chk1(sdo, 1'b0);
        chk1(tip_en, 1'b1);
        setc(3'h5);
        chk1(tip_en, 1'b0);
        wb(1'b1, 8'h10, 32'h0000_0F35); // active 5, tip 6, rev 4, meas 7
        $display("test regs done");
    endtask
    task automatic t_open();
        setc(3'h0);
        chk1(sdo, 1'b1);
        chk32({29'h0, pwr, tip_en, relay}, 32'h0000_0000);
        ce <= 1'b0;
        setc(3'h1);
        chk1(relay, 1'b0); // enable low freezes the decoder
        ce <= 1'b1;
        tick(8);
        chk1(relay, 1'b1);
        setc(3'h0);
        therm <= 1'b1;
        tick(8);
        chk1(sdo, 1'b0);
        therm <= 1'b0;
        rtrip <= 1'b0;
        setc(3'h1);
        chk1(relay, 1'b1);
        chk1(sdo, 1'b1);
        rtrip <= 1'b1;
        tick(70);
        chk1(sdo, 1'b0);
        chk1(offhook, 1'b1);
        rtrip <= 1'b0;
        $display("test open and ring done");
    endtask
    task automatic t_active();
        setc(3'h5);
        chk1(sdo, 1'b0);
        loop_oh <= 1'b0;
        tick(8);
        chk1(sdo, 1'b1);
        setc(3'h6);
        chk32({30'h0, tip_en, ring_en}, 32'h0000_0001);
        loop_oh <= 1'b1;
        setc(3'h4);
        chk32({30'h0, rev, sdo}, 32'h0000_0002);
        wb(1'b1, 8'h00, 32'h0000_0001);
        gkey <= 1'b1;
        setc(3'h5);
        chk1(sdo, 1'b1);
        wb(1'b1, 8'h00, 32'h0);
        gkey <= 1'b0;
        $display("test active done");
    endtask
    task automatic t_meas();
        wb(1'b1, 8'h0C, 32'h0000_0004);
        mv <= 16'h03E8;
        tick(8);
        code <= 3'h7; // from active, measurement pulse routed
        n = 0;
        while (sdo !== 1'b1 && n < 8) begin
            @(posedge clk);
            n++;
        end
        chk1(sdo, 1'b1);
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (sdo === 1'b1 && n < 400);
        chk1(n >= 137 && n <= 139, 1'b1); // 1000 mV
        tick(4);
        chk1(irq, 1'b1);
        wb(1'b0, 8'h08, 32'h0);
        chk32(q & 32'h0000_0004, 32'h0000_0004);
        wb(1'b1, 8'h08, 32'h0000_0004);
        tick(2);
        chk1(irq, 1'b0);
        wb(1'b0, 8'h14, 32'h0);
        chk32(q, 32'h0000_03E8);
        wb(1'b0, 8'h04, 32'h0);
        chk32(q, 32'h0000_0005);
        setc(3'h0);
        setc(3'h7);
        chk1(sdo, 1'b0); // entry from open refused
        setc(3'h2);
        chk1(pwr, 1'b0); // unlisted code
        chk1(sdo, 1'b1);
        wb(1'b1, 8'h00, 32'h0000_0006);
        tick(2);
        chk1(relay, 1'b1); // software code
        wb(1'b1, 8'h00, 32'h0);
        $display("test measure done");
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // hang guard at 20000 cycles, well past the few hundred cycles the tests need
    initial begin
        #(40 * 20000);
        mismatches++;
        end_sim();
    end
    initial begin
        {rst_n, loop_oh, gkey, rtrip, therm, cyc, stb, we} = 8'h00;
        rel = 1'b1;
        ce = 1'b1;
        code = 3'h0;
        mv = 16'h0;
        adr = 8'h0;
        wdat = 32'h0;
        tick(10);
        chk1(sdo, 1'b1);
        rst_n <= 1'b1;
        rel <= 1'b0;
        t_regs();
        t_open();
        t_active();
        t_meas();
        end_sim();
    end
endmodule
`default_nettype wire
